// ===== hdl/pra_pkg.sv
// constants shared by the register-access slave of the potentiometer
// assumes a 100 MHz system clock and an open-drain serial bus outside
package pra_pkg;
    localparam logic [7:0] ADDR_WIPER = 8'h00;
    localparam logic [7:0] ADDR_RSVD = 8'h01;
    localparam logic [7:0] ADDR_ACCESS_SELECT = 8'h02;
    localparam logic [7:0] ACCESS_SELECT_RESET = 8'h00;
    localparam int ACCESS_SELECT_BIT = 7;
    localparam int WIPER_W = 7;
    // wiper value shown before the stored value is loaded
    localparam logic [6:0] WIPER_PRELOAD = 7'h40;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // device-type prefix of the identification byte; value is arbitrary
    localparam logic [4:0] ID_PREFIX_DEF = 5'h16;
    localparam int ID_DIR_BIT = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYS_CLK_MHZ = 100;
    localparam int NV_WRITE_TIME_NS = 10000000;
    localparam int NV_WRITE_CYCLES_DEF =
        (NV_WRITE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int NV_CNT_W = 24;

    typedef enum logic [2:0] {
        PRA_IDLE = 3'h0,
        PRA_ID = 3'h1,
        PRA_ADDR = 3'h2,
        PRA_WDATA = 3'h3,
        PRA_RDATA = 3'h4,
        PRA_DONE = 3'h5,
        PRA_NVWAIT = 3'h6
    } pra_state_t;
endpackage

// ===== hdl/pra_pot_register_access_slave.sv
// serial-bus slave giving access to wiper, power-up value and access select
// assumes scl/sda/straps arrive as raw pins; link_clk oversamples them and
// the stored power-up value lives in the sys_clk domain
`timescale 1ns/100ps

module pra_pot_register_access_slave
    import pra_pkg::*;
#(
    parameter logic [4:0] ID_PREFIX = ID_PREFIX_DEF,
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic strap_bit_high,
    input wire logic strap_bit_low,
    input wire logic [7:0] nv_image,
    output logic [6:0] wiper_position,
    output logic [7:0] power_up_wiper_value,
    output logic nv_write_strobe,
    output logic nv_write_busy
);
    // sys_clk domain
    logic loaded_ff, ivr_tgl_ff, nv_busy_ff, nv_strobe_ff;
    logic [7:0] ivr_ff;
    logic [NV_CNT_W-1:0] nv_cnt_ff;
    logic rq_s1_ff, rq_s2_ff, rq_q_ff;
    // link_clk domain
    logic lrst_s1_ff, lrst_ff;
    logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_f_ff, pin_q_ff;
    logic iv_s1_ff, iv_s2_ff, iv_q_ff, bz_s1_ff, bz_s2_ff, busy_seen_ff;
    pra_state_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sreg_ff, nxt_sreg, addr_ff, nxt_addr, txd_ff, nxt_txd;
    logic [7:0] acr_ff, nxt_acr, ivr_sh_ff, nxt_ivr_sh;
    logic [7:0] nv_data_ff, nxt_nv_data;
    logic [6:0] wiper_ff, nxt_wiper;
    logic ack_ff, nxt_ack, rd_ff, nxt_rd, mack_ff, nxt_mack;
    logic pend_ff, nxt_pend, oe_ff, nxt_oe, req_tgl_ff, nxt_req_tgl;
    logic sda_out_ff;

    // sys side: stored value, load at power-up, write cycle timing
    wire rq_evt = rq_s2_ff ^ rq_q_ff;
    wire nv_last = (nv_cnt_ff == '0);
    always_ff @(posedge sys_clk) begin
        rq_s1_ff <= req_tgl_ff;
        rq_s2_ff <= rq_s1_ff;
        rq_q_ff <= rq_s2_ff;
        nv_strobe_ff <= 1'b0;
        if (rst) begin
            rq_s1_ff <= 1'b0;
            rq_s2_ff <= 1'b0;
            rq_q_ff <= 1'b0;
            loaded_ff <= 1'b0;
            ivr_ff <= 8'h00;
            ivr_tgl_ff <= 1'b0;
            nv_busy_ff <= 1'b0;
            nv_cnt_ff <= '0;
        end else if (!loaded_ff) begin
            // stored image is caught after release, then sent to the link
            loaded_ff <= 1'b1;
            ivr_ff <= nv_image;
            ivr_tgl_ff <= ~ivr_tgl_ff;
        end else if (nv_busy_ff) begin
            nv_cnt_ff <= nv_cnt_ff - 1'b1;
            if (nv_last) begin
                nv_busy_ff <= 1'b0;
                ivr_tgl_ff <= ~ivr_tgl_ff;
            end
        end else if (rq_evt) begin
            // nv_data_ff is held steady by the link until busy ends
            ivr_ff <= nv_data_ff;
            nv_busy_ff <= 1'b1;
            nv_strobe_ff <= 1'b1;
            nv_cnt_ff <= NV_CNT_W'(NV_WRITE_CYCLES - 1);
        end
    end

    // link side: reset, pin synchronisers and the bus state machine
    wire [3:0] pin_raw = {strap_bit_high, strap_bit_low, sda_in, scl_in};
    // a pin change counts only when the second and third stages agree
    wire [3:0] pin_agree = pin_s2_ff ~^ pin_s3_ff;
    wire [3:0] nxt_pin_f = (pin_agree & pin_s2_ff) | (~pin_agree & pin_f_ff);
    always_ff @(posedge link_clk) begin
        lrst_s1_ff <= rst;
        lrst_ff <= lrst_s1_ff;
        pin_s1_ff <= pin_raw;
        pin_s2_ff <= pin_s1_ff;
        pin_s3_ff <= pin_s2_ff;
        pin_f_ff <= nxt_pin_f;
        pin_q_ff <= pin_f_ff;
        iv_s1_ff <= ivr_tgl_ff;
        iv_s2_ff <= iv_s1_ff;
        iv_q_ff <= iv_s2_ff;
        bz_s1_ff <= nv_busy_ff;
        bz_s2_ff <= bz_s1_ff;
        if (lrst_ff) begin
            pin_s1_ff <= 4'hF;
            pin_s2_ff <= 4'hF;
            pin_s3_ff <= 4'hF;
            pin_f_ff <= 4'hF;
            pin_q_ff <= 4'hF;
            iv_s1_ff <= 1'b0;
            iv_s2_ff <= 1'b0;
            iv_q_ff <= 1'b0;
            bz_s1_ff <= 1'b0;
            bz_s2_ff <= 1'b0;
        end
    end
    wire scl_f = pin_f_ff[0];
    wire scl_q = pin_q_ff[0];
    wire sda_f = pin_f_ff[1];
    wire sda_q = pin_q_ff[1];
    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_det = scl_f & scl_q & ~sda_f & sda_q;
    wire stop_det = scl_f & scl_q & sda_f & ~sda_q;
    wire ivr_evt = iv_s2_ff ^ iv_q_ff;
    wire busy_l = bz_s2_ff;
    wire byte_end = (cnt_ff == BITS_PER_BYTE);
    wire rx_state = (st_ff == PRA_ID) | (st_ff == PRA_ADDR) |
                    (st_ff == PRA_WDATA);
    wire id_ok = (sreg_ff[7:3] == ID_PREFIX) &
                 (sreg_ff[2:1] == pin_f_ff[3:2]);
    wire sel_wiper = acr_ff[ACCESS_SELECT_BIT];
    wire [7:0] wiper_rd = {1'b0, wiper_ff};
    wire [7:0] addr0_rd = sel_wiper ? wiper_rd : ivr_sh_ff;
    wire [7:0] rd_val = (addr_ff == ADDR_WIPER) ? addr0_rd :
                        (addr_ff == ADDR_ACCESS_SELECT) ? acr_ff : RSVD_READ;
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_ack = ack_ff;
        nxt_sreg = sreg_ff;
        nxt_addr = addr_ff;
        nxt_txd = txd_ff;
        nxt_rd = rd_ff;
        nxt_mack = mack_ff;
        nxt_pend = pend_ff;
        nxt_oe = oe_ff;
        nxt_acr = acr_ff;
        nxt_wiper = wiper_ff;
        nxt_ivr_sh = ivr_sh_ff;
        nxt_nv_data = nv_data_ff;
        nxt_req_tgl = req_tgl_ff;
        if (ivr_evt) begin
            nxt_ivr_sh = ivr_ff;
            nxt_wiper = ivr_ff[WIPER_W-1:0];
        end
        if (st_ff == PRA_NVWAIT) begin
            nxt_oe = 1'b0;
            if (busy_seen_ff && !busy_l) begin
                nxt_st = PRA_IDLE;
            end
        end else if (start_det) begin
            nxt_st = PRA_ID;
            nxt_cnt = 4'h0;
            nxt_ack = 1'b0;
            nxt_oe = 1'b0;
            nxt_pend = 1'b0;
        end else if (stop_det) begin
            nxt_oe = 1'b0;
            nxt_pend = 1'b0;
            nxt_st = PRA_IDLE;
            if (pend_ff) begin
                nxt_req_tgl = ~req_tgl_ff;
                nxt_st = PRA_NVWAIT;
            end
        end else if (scl_rise) begin
            if (rx_state && !ack_ff) begin
                nxt_sreg = {sreg_ff[6:0], sda_f};
                nxt_cnt = cnt_ff + 4'h1;
            end
            if (st_ff == PRA_RDATA && ack_ff) begin
                nxt_mack = ~sda_f;
            end
        end else if (scl_fall) begin
            if (rx_state && !ack_ff && byte_end) begin
                nxt_ack = 1'b1;
                nxt_oe = 1'b1;
                case (st_ff)
                    PRA_ID: begin
                        nxt_rd = sreg_ff[ID_DIR_BIT];
                        if (!id_ok) begin
                            nxt_ack = 1'b0;
                            nxt_oe = 1'b0;
                            nxt_st = PRA_IDLE;
                        end
                    end
                    PRA_ADDR: begin
                        nxt_addr = sreg_ff;
                    end
                    PRA_WDATA: begin
                        if (addr_ff == ADDR_WIPER) begin
                            nxt_wiper = sreg_ff[WIPER_W-1:0];
                            // stored value and wiper take the same byte
                            nxt_nv_data = sreg_ff;
                            nxt_pend = ~sel_wiper;
                        end
                        if (addr_ff == ADDR_ACCESS_SELECT) begin
                            nxt_acr = sreg_ff;
                        end
                    end
                    default: begin
                        nxt_ack = 1'b0;
                    end
                endcase
            end else if (rx_state && ack_ff) begin
                nxt_ack = 1'b0;
                nxt_oe = 1'b0;
                nxt_cnt = 4'h0;
                case (st_ff)
                    PRA_ID: begin
                        if (rd_ff) begin
                            nxt_st = PRA_RDATA;
                            nxt_oe = ~rd_val[7];
                            nxt_txd = {rd_val[6:0], 1'b0};
                            nxt_cnt = 4'h1;
                        end else begin
                            nxt_st = PRA_ADDR;
                        end
                    end
                    PRA_ADDR: nxt_st = PRA_WDATA;
                    default: nxt_st = PRA_DONE;
                endcase
            end else if (st_ff == PRA_RDATA) begin
                if (ack_ff) begin
                    nxt_ack = 1'b0;
                    nxt_oe = 1'b0;
                    nxt_st = PRA_DONE;
                    if (mack_ff) begin
                        // master wants more: the same byte is sent again
                        nxt_st = PRA_RDATA;
                        nxt_oe = ~rd_val[7];
                        nxt_txd = {rd_val[6:0], 1'b0};
                        nxt_cnt = 4'h1;
                    end
                end else if (byte_end) begin
                    nxt_oe = 1'b0;
                    nxt_ack = 1'b1;
                end else begin
                    nxt_oe = ~txd_ff[7];
                    nxt_txd = {txd_ff[6:0], 1'b0};
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end else if (st_ff == PRA_DONE) begin
                // a full extra pulse voids the store; the stop's own rise
                // is not a pulse, so it must not cancel the launch
                nxt_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        st_ff <= nxt_st;
        cnt_ff <= nxt_cnt;
        ack_ff <= nxt_ack;
        sreg_ff <= nxt_sreg;
        addr_ff <= nxt_addr;
        txd_ff <= nxt_txd;
        rd_ff <= nxt_rd;
        mack_ff <= nxt_mack;
        pend_ff <= nxt_pend;
        oe_ff <= nxt_oe;
        if (lrst_ff) begin
            st_ff <= PRA_IDLE;
            cnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            sreg_ff <= 8'h00;
            addr_ff <= ADDR_WIPER;
            txd_ff <= 8'h00;
            rd_ff <= 1'b0;
            mack_ff <= 1'b0;
            pend_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        acr_ff <= nxt_acr;
        wiper_ff <= nxt_wiper;
        ivr_sh_ff <= nxt_ivr_sh;
        nv_data_ff <= nxt_nv_data;
        req_tgl_ff <= nxt_req_tgl;
        busy_seen_ff <= (st_ff == PRA_NVWAIT) & (busy_seen_ff | busy_l);
        sda_out_ff <= 1'b0;
        if (lrst_ff) begin
            acr_ff <= ACCESS_SELECT_RESET;
            wiper_ff <= WIPER_PRELOAD;
            ivr_sh_ff <= 8'h00;
            nv_data_ff <= 8'h00;
            req_tgl_ff <= 1'b0;
            busy_seen_ff <= 1'b0;
        end
    end
    assign sda_out = sda_out_ff;
    assign sda_oe = oe_ff;
    assign wiper_position = wiper_ff;
    assign power_up_wiper_value = ivr_ff;
    assign nv_write_strobe = nv_strobe_ff;
    assign nv_write_busy = nv_busy_ff;

    chk_nv_only_stop: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $changed(req_tgl_ff) |-> $past(stop_det) && $past(pend_ff))
        else $error("non-volatile launch without stop");
    chk_nv_select_zero: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $changed(req_tgl_ff) |-> !acr_ff[ACCESS_SELECT_BIT]
            && addr_ff == ADDR_WIPER)
        else $error("launch with wrong select or address");
    chk_nv_same_wiper: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $changed(req_tgl_ff) |-> nv_data_ff[6:0] == wiper_ff)
        else $error("stored value differs from wiper");
    chk_busy_quiet: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        st_ff == PRA_NVWAIT |=> !oe_ff)
        else $error("sda driven during write cycle");
    chk_id_ack_match: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $rose(oe_ff) && st_ff == PRA_ID |-> id_ok && ack_ff)
        else $error("ack of foreign identification");
    chk_select_write: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $changed(acr_ff) |-> $past(addr_ff) == ADDR_ACCESS_SELECT
            && $past(scl_fall) && $past(st_ff) == PRA_WDATA)
        else $error("select changed outside its write");
    chk_read_keeps_wiper: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        st_ff == PRA_RDATA && !ivr_evt |=> $stable(wiper_ff))
        else $error("wiper moved during read");
    chk_select_reset: assert property (
        @(posedge link_clk)
        $fell(lrst_ff) |-> acr_ff == ACCESS_SELECT_RESET)
        else $error("select not cleared at power-up");
    chk_busy_length: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(nv_busy_ff) |-> nv_busy_ff [*8] ##0 $past(nv_strobe_ff, 7))
        else $error("write cycle too short");
endmodule

// ===== tb/pra_bus_master.sv
// bus master model that drives the serial clock and data toward the slave
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
module pra_bus_master #(
    parameter int HALF = 10
) (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    // clock stands high and data is released between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves a little after the clock fall, so no false start/stop
    task automatic clock_bit(input logic b, output logic seen);
        pause(3);
        sda_drv = b;
        pause(HALF - 3);
        scl = 1'b1;
        pause(HALF);
        seen = sda_wire;
        scl = 1'b0;
    endtask
    // first or repeated start
    task automatic start_cond();
        pause(3);
        sda_drv = 1'b1;
        pause(HALF - 3);
        scl = 1'b1;
        pause(HALF);
        sda_drv = 1'b0;
        pause(HALF);
        scl = 1'b0;
    endtask
    // closes a frame with a stop, reads included
    task automatic stop_cond();
        pause(3);
        sda_drv = 1'b0;
        pause(HALF - 3);
        scl = 1'b1;
        pause(HALF);
        sda_drv = 1'b1;
        pause(HALF);
    endtask
    // n below 8 cuts the byte short on purpose, with no ack slot
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            clock_bit(d[i], s);
        end
        ack = 1'b0;
        if (n == 8) begin
            clock_bit(1'b1, s);
            ack = ~s;
        end
    endtask
    task automatic receive(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(nack, s);
    endtask
endmodule

// ===== tb/pra_pot_register_access_slave_tb.sv
// self-checking bench for the register-access slave of the potentiometer
// assumes the bus master model and a pulled-up data wire
`timescale 1ns/100ps
module pra_pot_register_access_slave_tb;
    import pra_pkg::*;
    localparam int NV_CYC = 400;
    localparam int LIMIT = 30000;
    localparam logic [7:0] NV_IMG = 8'h9A;
    localparam logic [7:0] ID_W = {ID_PREFIX_DEF, 2'b10, 1'b0};
    localparam logic [7:0] ID_R = {ID_PREFIX_DEF, 2'b10, 1'b1};
    localparam logic [7:0] ID_BAD = {ID_PREFIX_DEF, 2'b01, 1'b0};
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_drv, sda_wire, sda_out, sda_oe;
    logic [6:0] wiper_position;
    logic [7:0] power_up_wiper_value;
    logic nv_write_strobe, nv_write_busy;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_strobe = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    // offset start keeps the link clock out of step with sys_clk
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_drv;
    pra_pot_register_access_slave #(
        .ID_PREFIX(ID_PREFIX_DEF),
        .NV_WRITE_CYCLES(NV_CYC)
    ) u_pra_pot_register_access_slave (
        .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_bit_high(1'b1), .strap_bit_low(1'b0),
        .nv_image(NV_IMG), .wiper_position(wiper_position),
        .power_up_wiper_value(power_up_wiper_value),
        .nv_write_strobe(nv_write_strobe), .nv_write_busy(nv_write_busy)
    );
    pra_bus_master u_pra_bus_master (
        .clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv)
    );
    task automatic test_done();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (nv_write_strobe === 1'b1) begin
            n_strobe++;
        end
        if (nv_write_busy === 1'b1 && sda_oe !== 1'b0) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, sda_oe,
                1'b0);
        end
        if (cycles == LIMIT) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic wr(input logic [7:0] id, input logic [7:0] a,
            input logic [7:0] d, input logic stop_it, input logic [7:0] acks);
        logic k1, k2, k3;
        u_pra_bus_master.start_cond();
        u_pra_bus_master.send(id, 8, k1);
        u_pra_bus_master.send(a, 8, k2);
        u_pra_bus_master.send(d, 8, k3);
        if (stop_it) begin
            u_pra_bus_master.stop_cond();
        end
        chk({5'h00, k1, k2, k3}, acks);
    endtask
    task automatic rd_tail(input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        u_pra_bus_master.start_cond();
        u_pra_bus_master.send(ID_R, 8, k);
        u_pra_bus_master.receive(1'b1, d);
        u_pra_bus_master.stop_cond();
        chk({7'h00, k}, 8'h01);
        chk(d, exp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic k1, k2;
        u_pra_bus_master.start_cond();
        u_pra_bus_master.send(ID_W, 8, k1);
        u_pra_bus_master.send(a, 8, k2);
        chk({6'h00, k1, k2}, 8'h03);
        rd_tail(exp);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int i;
        i = 0;
        while (nv_write_busy !== lvl && i < lim) begin
            @(negedge sys_clk);
            i++;
        end
        chk({7'h00, nv_write_busy}, {7'h00, lvl});
    endtask
    initial begin
        logic k;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (30) @(negedge sys_clk);
        chk(power_up_wiper_value, NV_IMG);
        chk({1'b0, wiper_position}, {1'b0, NV_IMG[6:0]});
        rd(ADDR_ACCESS_SELECT, ACCESS_SELECT_RESET);
        rd(ADDR_WIPER, NV_IMG);
        // the reserved address is never addressed by this master
        rd(ADDR_WIPER, NV_IMG);
        chk({1'b0, wiper_position}, {1'b0, NV_IMG[6:0]});
        wr(ID_W, ADDR_ACCESS_SELECT, 8'h80, 1'b1, 8'h07);
        rd(ADDR_ACCESS_SELECT, 8'h80);
        wr(ID_W, ADDR_WIPER, 8'h25, 1'b1, 8'h07);
        chk({1'b0, wiper_position}, 8'h25);
        chk(power_up_wiper_value, NV_IMG);
        rd(ADDR_WIPER, 8'h25);
        // data byte cut short after five bits must change nothing
        u_pra_bus_master.start_cond();
        u_pra_bus_master.send(ID_W, 8, k);
        u_pra_bus_master.send(ADDR_WIPER, 8, k);
        u_pra_bus_master.send(8'h7F, 5, k);
        u_pra_bus_master.stop_cond();
        wr(ID_BAD, ADDR_WIPER, 8'h33, 1'b1, 8'h00);
        chk({1'b0, wiper_position}, 8'h25);
        wr(ID_W, ADDR_ACCESS_SELECT, 8'h00, 1'b1, 8'h07);
        wr(ID_W, ADDR_WIPER, 8'h77, 1'b1, 8'h07);
        wait_busy(1'b1, 50);
        chk({1'b0, wiper_position}, 8'h77);
        chk(power_up_wiper_value, 8'h77);
        // a command during the store cycle gets no answer
        u_pra_bus_master.start_cond();
        u_pra_bus_master.send(ID_W, 8, k);
        chk({7'h00, k}, 8'h00);
        u_pra_bus_master.stop_cond();
        wait_busy(1'b0, 1000);
        repeat (20) @(negedge sys_clk);
        wr(ID_W, ADDR_WIPER, 8'h11, 1'b0, 8'h07);
        rd_tail(8'h77);
        chk({1'b0, wiper_position}, 8'h11);
        chk(n_strobe[7:0], 8'h01);
        chk(power_up_wiper_value, 8'h77);
        test_done();
    end
endmodule
